// file: logic/chgtc_defs.svh
// Offsets, field positions, reset values and timing counts of the charger control block
`ifndef CHGTC_DEFS_SVH
`define CHGTC_DEFS_SVH
`define CHGTC_OFS_DATA_LINE 8'hd2
`define CHGTC_OFS_TYPEC 8'hd4
`define CHGTC_OFS_CFG_BASE 8'hd5
`define CHGTC_CFG_COUNT 16
`define CHGTC_CFG_LOCK_IDX 6
`define CHGTC_OFS_MISC 8'he5
`define CHGTC_DL_RESET 8'h02
`define CHGTC_TC_RESET 8'h1f
`define CHGTC_MISC_RESET 8'h00
`define CHGTC_BIT_DL_MAN 6
`define CHGTC_BIT_DL_AUTO 1
`define CHGTC_BIT_FORCE 5
`define CHGTC_BIT_TRYSNK 4
`define CHGTC_BIT_LP 1
`define CHGTC_BIT_OTG 0
`define CHGTC_BIT_AUX_USAGE 0
`define CHGTC_BIT_AUX_CTL 1
`define CHGTC_BIT_AUX_MAN 2
`define CHGTC_BIT_FSHIP 3
`define CHGTC_BIT_QRST 4
`define CHGTC_UNLOCK_CODE 2'b11
`define CHGTC_STATE_SOURCE 3'h2
`define CHGTC_DRV_3V3 2'h2
`define CHGTC_ILIM_DEFAULT 7'h0c
`define CHGTC_CV_DEFAULT 8'h18
`define CHGTC_CC_DEFAULT 8'h0a
`define CHGTC_CLK_HZ 20000000
`define CHGTC_TICK_HZ 1000
`define CHGTC_TICK_CYC (`CHGTC_CLK_HZ / `CHGTC_TICK_HZ)
`define CHGTC_EXIT_SHIP_MS 10
`define CHGTC_RESET_MS 10000
`define CHGTC_BLINK_HALF_MS 500
`endif

// file: logic/chgtc_pkg.sv
// Types of the charger control block
package chgtc_pkg;
   typedef enum logic [1:0] {
      CHGTC_CHG_IDLE, CHGTC_CHG_ACTIVE, CHGTC_CHG_TOPOFF, CHGTC_CHG_FAULT
   } chgtc_chg_t;
   typedef enum logic [1:0] {
      CHGTC_DET_IDLE, CHGTC_DET_RUN, CHGTC_DET_DONE
   } chgtc_det_t;
   typedef struct packed {
      logic force_recovery;
      logic prefer_sink_enable;
      logic [1:0] port_role_select;
      logic low_power_sink_detect;
      logic reverse_boost_trigger_select;
   } chgtc_typec_t;
   typedef struct packed {
      logic [1:0] positive_line_drive_sel;
      logic [1:0] negative_line_drive_sel;
   } chgtc_lines_t;
endpackage : chgtc_pkg

// file: logic/chgtc_core.sv
// Register bank, line control, status pins and ship-exit timing of the charger
//
// Behaviour
// RQ1 - Abort flag blocks and immediately stops charger type detection.
// RQ2 - Detection runs when enabled, abort clear and bus valid after debounce.
// RQ3 - Manual bit picks detection or per-line drive fields for data lines; the code ignores it while the auto bit is set.
// RQ4 - Drive codes: 0 pull-down, 1 0.6V, 2 3.3V, 3 open.
// RQ5 - Auto bit drives both lines 3.3V while port state is source.
// RQ6 - Force-error bit holds port state machine in recovery.
// RQ7 - Recovery drops terminations, then restarts unattached search by role.
// RQ8 - Host clears force-error bit itself after recovery.
// RQ9 - Try-sink bit enables prefer-sink behaviour.
// RQ10 - Role field: 1 sink, 2 source, 3 dual role.
// RQ11 - Low-power bit selects small sink-detect current source.
// RQ12 - Trigger bit picks charger mode or port state for reverse boost.
// RQ13 - Config registers locked until unlock code written in register six.
// RQ14 - Input current limit code seven bits, default from detection result.
// RQ15 - Regulation voltage code six bits, default 0x18.
// RQ16 - Fast-charge current code six bits, default 0x0A.
// RQ17 - Top-off entered after current at threshold for termination time.
// RQ18 - Input-good low with valid switching input or reverse boost.
// RQ19 - Charge status: off idle/fault, 1Hz blink charging, low top-off.
// RQ20 - Usage bit selects aux meaning; control bit gives host manual level.
// RQ21 - Host sets usage bit for detection-done signalling.
// RQ22 - Fault mode: aux starts high, goes low on faults.
// RQ23 - Detection mode: starts low, high on standard or downstream port.
// RQ24 - Ship mode left after exit input high 10ms; battery switch on.
// RQ25 - Without input, 10s hold opens battery switch until release.
// RQ26 - Hold times and blink come from a millisecond timebase.
`timescale 1ns/10ps
`default_nettype none
`include "chgtc_defs.svh"
module chgtc_core
   import chgtc_pkg::*;
#(
   parameter int EXIT_SHIP_MS = `CHGTC_EXIT_SHIP_MS,
   parameter int RESET_MS = `CHGTC_RESET_MS,
   parameter int BLINK_HALF_MS = `CHGTC_BLINK_HALF_MS,
   parameter int TICK_CYC = `CHGTC_TICK_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic detection_abort_flag,
   input wire logic charger_detect_enable,
   input wire logic bus_valid_debounced,
   input wire logic detect_done,
   input wire logic detect_dedicated_port,
   input wire logic [6:0] detect_ilim_code,
   input wire logic [2:0] port_connection_state,
   input wire logic [1:0] detect_line_drive_pos,
   input wire logic [1:0] detect_line_drive_neg,
   input wire logic charger_mode_boost,
   input wire logic input_valid,
   input wire logic buck_switching,
   input wire logic charging_active,
   input wire logic charge_topoff_or_done,
   input wire logic charge_fault,
   input wire logic timer_fault,
   input wire logic thermal_shutdown,
   input wire logic sys_lockout,
   input wire logic ship_exit_input,
   output logic detect_run,
   output chgtc_lines_t line_drive,
   output chgtc_typec_t typec_ctrl,
   output logic reverse_boost_enable,
   output logic [6:0] input_current_limit_code,
   output logic [5:0] battery_regulation_voltage_code,
   output logic [5:0] fast_charge_current_code,
   output logic [3:0] topoff_threshold_code,
   output logic [2:0] topoff_time_code,
   output logic battery_switch_on,
   output logic input_good_n_oe,
   output logic charge_status_n_oe,
   output logic aux_status_n_oe
);
   logic [7:0] dl_q, dl_d, tc_q, tc_d, misc_q, misc_d;
   logic [7:0] cfg_q [`CHGTC_CFG_COUNT];
   logic [7:0] cfg_d [`CHGTC_CFG_COUNT];
   logic ilim_seen_q, ilim_seen_d;
   logic [7:0] rdata_q, rdata_d;
   logic unlocked;
   chgtc_det_t det_q, det_d;
   logic aux_flag_q, aux_flag_d;
   logic [15:0] tick_cnt_q, tick_cnt_d;
   logic tick;
   logic ext_s1_q, ext_s2_q;
   logic [15:0] hold_q, hold_d;
   logic [9:0] blink_cnt_q, blink_cnt_d;
   logic blink_q, blink_d;
   logic qbat_off_q, qbat_off_d;
   logic [7:0] cfg_off;

   assign cfg_off = reg_addr - `CHGTC_OFS_CFG_BASE;
   // RQ13 lock check
   assign unlocked = (cfg_q[`CHGTC_CFG_LOCK_IDX][3:2] == `CHGTC_UNLOCK_CODE);

   always_comb begin
      dl_d = dl_q;
      tc_d = tc_q;
      misc_d = misc_q;
      rdata_d = 8'h00;
      ilim_seen_d = ilim_seen_q;
      for (int i = 0; i < `CHGTC_CFG_COUNT; i++) begin
         cfg_d[i] = cfg_q[i];
      end
      // RQ14 default from detection
      if (!ilim_seen_q && detect_done) begin
         cfg_d[1] = {1'b0, detect_ilim_code};
         ilim_seen_d = 1'b1;
      end
      // RQ24 ship flag cleared after exit hold
      if (misc_q[`CHGTC_BIT_FSHIP] && ext_s2_q && hold_q >= 16'(EXIT_SHIP_MS)) begin
         misc_d[`CHGTC_BIT_FSHIP] = 1'b0;
      end
      if (reg_wr) begin
         if (reg_addr == `CHGTC_OFS_DATA_LINE) begin
            dl_d = reg_wdata & 8'h7e;
         end else if (reg_addr == `CHGTC_OFS_TYPEC) begin
            // RQ6 host-owned force bit
            tc_d = reg_wdata & 8'h3f;
         end else if (reg_addr == `CHGTC_OFS_MISC) begin
            misc_d = reg_wdata & 8'h1f;
         end else if (cfg_off < 8'(`CHGTC_CFG_COUNT)) begin
            // RQ13 write protection
            if (cfg_off == 8'(`CHGTC_CFG_LOCK_IDX) || unlocked) begin
               cfg_d[cfg_off[3:0]] = reg_wdata;
            end
         end
      end
      if (reg_rd) begin
         if (reg_addr == `CHGTC_OFS_DATA_LINE) begin
            rdata_d = dl_q;
         end else if (reg_addr == `CHGTC_OFS_TYPEC) begin
            rdata_d = tc_q;
         end else if (reg_addr == `CHGTC_OFS_MISC) begin
            rdata_d = misc_q;
         end else if (cfg_off < 8'(`CHGTC_CFG_COUNT)) begin
            rdata_d = cfg_q[cfg_off[3:0]];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         dl_q <= `CHGTC_DL_RESET;
         tc_q <= `CHGTC_TC_RESET;
         misc_q <= `CHGTC_MISC_RESET;
         rdata_q <= 8'h00;
         ilim_seen_q <= 1'b0;
         for (int i = 0; i < `CHGTC_CFG_COUNT; i++) begin
            cfg_q[i] <= 8'h00;
         end
         cfg_q[1] <= {1'b0, `CHGTC_ILIM_DEFAULT};
         cfg_q[2] <= `CHGTC_CV_DEFAULT;
         cfg_q[3] <= `CHGTC_CC_DEFAULT;
      end else begin
         dl_q <= dl_d;
         tc_q <= tc_d;
         misc_q <= misc_d;
         rdata_q <= rdata_d;
         ilim_seen_q <= ilim_seen_d;
         for (int i = 0; i < `CHGTC_CFG_COUNT; i++) begin
            cfg_q[i] <= cfg_d[i];
         end
      end
   end
   assign reg_rdata = rdata_q;

   // RQ14 input limit code
   assign input_current_limit_code = cfg_q[1][6:0];
   // RQ15 regulation code
   assign battery_regulation_voltage_code = cfg_q[2][5:0];
   // RQ16 fast-charge code
   assign fast_charge_current_code = cfg_q[3][5:0];
   // RQ17 top-off fields
   assign topoff_threshold_code = cfg_q[4][3:0];
   assign topoff_time_code = cfg_q[4][6:4];

   // RQ6 RQ7 RQ9 RQ10 RQ11 port controls
   assign typec_ctrl.force_recovery = tc_q[`CHGTC_BIT_FORCE];
   assign typec_ctrl.prefer_sink_enable = tc_q[`CHGTC_BIT_TRYSNK];
   assign typec_ctrl.port_role_select = tc_q[3:2];
   assign typec_ctrl.low_power_sink_detect = tc_q[`CHGTC_BIT_LP];
   assign typec_ctrl.reverse_boost_trigger_select = tc_q[`CHGTC_BIT_OTG];

   // RQ12 boost trigger select
   assign reverse_boost_enable = tc_q[`CHGTC_BIT_OTG]
      ? (port_connection_state == `CHGTC_STATE_SOURCE) : charger_mode_boost;

   // Detection sequencer
   always_comb begin
      det_d = det_q;
      case (det_q)
         CHGTC_DET_IDLE: begin
            // RQ2 start condition
            if (!detection_abort_flag && charger_detect_enable && bus_valid_debounced) begin
               det_d = CHGTC_DET_RUN;
            end
         end
         CHGTC_DET_RUN: begin
            // RQ1 abort stops run
            if (detection_abort_flag) begin
               det_d = CHGTC_DET_IDLE;
            end else if (detect_done) begin
               det_d = CHGTC_DET_DONE;
            end
         end
         CHGTC_DET_DONE: begin
            if (!bus_valid_debounced || !charger_detect_enable) begin
               det_d = CHGTC_DET_IDLE;
            end
         end
         default: det_d = CHGTC_DET_IDLE;
      endcase
   end
   // RQ1 no run while aborted
   assign detect_run = (det_q == CHGTC_DET_RUN) && !detection_abort_flag;

   // RQ3 RQ4 RQ5 line drive source
   always_comb begin
      if (dl_q[`CHGTC_BIT_DL_AUTO]) begin
         if (port_connection_state == `CHGTC_STATE_SOURCE) begin
            line_drive = '{`CHGTC_DRV_3V3, `CHGTC_DRV_3V3};
         end else begin
            line_drive = '{detect_line_drive_pos, detect_line_drive_neg};
         end
      end else if (dl_q[`CHGTC_BIT_DL_MAN]) begin
         line_drive = '{dl_q[5:4], dl_q[3:2]};
      end else begin
         line_drive = '{detect_line_drive_pos, detect_line_drive_neg};
      end
   end

   // RQ26 millisecond timebase
   assign tick = (tick_cnt_q == 16'(TICK_CYC - 1));
   always_comb begin
      tick_cnt_d = tick ? 16'h0000 : tick_cnt_q + 16'h0001;
      blink_cnt_d = blink_cnt_q;
      blink_d = blink_q;
      hold_d = hold_q;
      qbat_off_d = qbat_off_q;
      aux_flag_d = aux_flag_q;
      if (tick) begin
         // RQ19 half-period count
         if (blink_cnt_q == 10'(BLINK_HALF_MS - 1)) begin
            blink_cnt_d = 10'h000;
            blink_d = !blink_q;
         end else begin
            blink_cnt_d = blink_cnt_q + 10'h001;
         end
      end
      // RQ26 hold counter on synced input
      if (!ext_s2_q) begin
         hold_d = 16'h0000;
         qbat_off_d = 1'b0;
      end else if (tick && hold_q != 16'hffff) begin
         hold_d = hold_q + 16'h0001;
      end
      // RQ25 long hold opens switch
      if (ext_s2_q && hold_q >= 16'(RESET_MS) && !misc_q[`CHGTC_BIT_FSHIP]
          && !misc_q[`CHGTC_BIT_QRST] && !input_valid) begin
         qbat_off_d = 1'b1;
      end
      // RQ22 RQ23 aux latched level
      if (misc_q[`CHGTC_BIT_AUX_USAGE]) begin
         if (det_q != CHGTC_DET_DONE) begin
            aux_flag_d = 1'b0;
         end else if (!detect_dedicated_port) begin
            aux_flag_d = 1'b1;
         end
      end else begin
         aux_flag_d = timer_fault || thermal_shutdown || sys_lockout;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         det_q <= CHGTC_DET_IDLE;
         tick_cnt_q <= 16'h0000;
         blink_cnt_q <= 10'h000;
         blink_q <= 1'b0;
         ext_s1_q <= 1'b0;
         ext_s2_q <= 1'b0;
         hold_q <= 16'h0000;
         qbat_off_q <= 1'b0;
         aux_flag_q <= 1'b0;
      end else begin
         det_q <= det_d;
         tick_cnt_q <= tick_cnt_d;
         blink_cnt_q <= blink_cnt_d;
         blink_q <= blink_d;
         ext_s1_q <= ship_exit_input;
         ext_s2_q <= ext_s1_q;
         hold_q <= hold_d;
         qbat_off_q <= qbat_off_d;
         aux_flag_q <= aux_flag_d;
      end
   end

   assign battery_switch_on = !misc_q[`CHGTC_BIT_FSHIP] && !qbat_off_q;

   // RQ18 input good pin
   assign input_good_n_oe = !((input_valid && buck_switching) || reverse_boost_enable);
   // RQ19 charge status pin
   assign charge_status_n_oe = charge_fault ? 1'b1
      : charge_topoff_or_done ? 1'b0
      : charging_active ? blink_q : 1'b1;
   // RQ20 aux pin source
   assign aux_status_n_oe = misc_q[`CHGTC_BIT_AUX_CTL] ? misc_q[`CHGTC_BIT_AUX_MAN]
      : (misc_q[`CHGTC_BIT_AUX_USAGE] ? aux_flag_q : !aux_flag_q);
endmodule : chgtc_core
`default_nettype wire

// file: testbench/chgtc_pins.sv
// Pull-up model of the three open-drain status pins seen by the host
`timescale 1ns/10ps
`default_nettype none
module chgtc_pins (
   input wire logic input_good_n_oe,
   input wire logic charge_status_n_oe,
   input wire logic aux_status_n_oe,
   output logic input_good_n,
   output logic charge_status_n,
   output logic aux_status_n
);
   // Released pins float up to the pull-up level
   assign input_good_n = input_good_n_oe ? 1'b1 : 1'b0;
   assign charge_status_n = charge_status_n_oe ? 1'b1 : 1'b0;
   assign aux_status_n = aux_status_n_oe ? 1'b1 : 1'b0;
endmodule : chgtc_pins
`default_nettype wire

// file: testbench/chgtc_core_chk.sv
// Port assertions of the charger control block
`timescale 1ns/10ps
`default_nettype none
module chgtc_core_chk
   import chgtc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic detection_abort_flag,
   input wire logic detect_run,
   input wire logic [2:0] port_connection_state,
   input wire logic charger_mode_boost,
   input wire logic reverse_boost_enable,
   input wire chgtc_typec_t typec_ctrl,
   input wire logic input_valid,
   input wire logic buck_switching,
   input wire logic charge_topoff_or_done,
   input wire logic charge_fault,
   input wire logic [5:0] battery_regulation_voltage_code,
   input wire logic [5:0] fast_charge_current_code,
   input wire logic input_good_n_oe,
   input wire logic charge_status_n_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   abort_stops_run_a: assert property (detection_abort_flag |-> !detect_run)
      else $error("detection runs while aborted");
   port_reset_val_a: assert property ($fell(rst) |-> typec_ctrl == 6'h1f)
      else $error("port control reset value wrong");
   cfg_reset_val_a: assert property ($fell(rst) |-> fast_charge_current_code == 6'h0a
      && battery_regulation_voltage_code == 6'h18) else $error("charger code reset wrong");
   port_write_a: assert property (reg_wr && reg_addr == 8'hd4
      |=> {2'b00, typec_ctrl} == ($past(reg_wdata) & 8'h3f)) else $error("port write lost");
   port_readback_a: assert property (reg_rd && !reg_wr && reg_addr == 8'hd4
      |=> reg_rdata == {2'b00, typec_ctrl}) else $error("port read data wrong");
   boost_source_a: assert property (reverse_boost_enable ==
      (typec_ctrl.reverse_boost_trigger_select ? port_connection_state == 3'h2
      : charger_mode_boost)) else $error("reverse boost source wrong");
   input_good_low_a: assert property ((input_valid && buck_switching)
      || reverse_boost_enable |-> ##[0:2] !input_good_n_oe) else $error("input good not low");
   status_fault_off_a: assert property (charge_fault [*3] |-> charge_status_n_oe)
      else $error("charge status driven on fault");
   status_topoff_on_a: assert property ((input_valid && !charge_fault
      && charge_topoff_or_done) [*3] |-> !charge_status_n_oe) else $error("top-off not low");
   cfg_hold_a: assert property (!reg_wr |=> $stable(fast_charge_current_code))
      else $error("charge code changed without write");
endmodule : chgtc_core_chk
`default_nettype wire

// file: testbench/chgtc_core_bench.sv
// Self-checking bench of the charger control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
   $display("unexpected %s: expected %0h, seen %0h", nm, e, g); end end
module chgtc_core_bench
   import chgtc_pkg::*;
;
   localparam int TICK = 4;
   localparam int EXIT_MS = 10;
   localparam int RST_MS = 20;
   localparam int HALF = 3 * TICK;
   logic clk, rst, reg_wr, reg_rd, detection_abort_flag, charger_detect_enable;
   logic bus_valid_debounced, detect_done, detect_dedicated_port, charger_mode_boost;
   logic input_valid, buck_switching, charging_active, charge_topoff_or_done, charge_fault;
   logic timer_fault, thermal_shutdown, sys_lockout, ship_exit_input, detect_run;
   logic reverse_boost_enable, battery_switch_on, input_good_n_oe, charge_status_n_oe;
   logic aux_status_n_oe, input_good_n, charge_status_n, aux_status_n;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rexp;
   logic [6:0] detect_ilim_code, input_current_limit_code;
   logic [2:0] port_connection_state, topoff_time_code;
   logic [1:0] detect_line_drive_pos, detect_line_drive_neg;
   logic [5:0] battery_regulation_voltage_code, fast_charge_current_code;
   logic [3:0] topoff_threshold_code;
   chgtc_lines_t line_drive;
   chgtc_typec_t typec_ctrl;
   logic rd_q = 1'b0;
   logic [7:0] exp_q[$];
   int error_cnt = 0, comparisons = 0, cycles = 0, n;
   integer seed = 32'h18d8_a177;
   chgtc_core #(.EXIT_SHIP_MS(EXIT_MS), .RESET_MS(RST_MS), .BLINK_HALF_MS(3), .TICK_CYC(TICK))
   i_chgtc_core (.clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
      .detection_abort_flag, .charger_detect_enable, .bus_valid_debounced, .detect_done,
      .detect_dedicated_port, .detect_ilim_code, .port_connection_state, .detect_line_drive_pos,
      .detect_line_drive_neg, .charger_mode_boost, .input_valid, .buck_switching,
      .charging_active, .charge_topoff_or_done, .charge_fault, .timer_fault, .thermal_shutdown,
      .sys_lockout, .ship_exit_input, .detect_run, .line_drive, .typec_ctrl,
      .reverse_boost_enable, .input_current_limit_code, .battery_regulation_voltage_code,
      .fast_charge_current_code, .topoff_threshold_code, .topoff_time_code, .battery_switch_on,
      .input_good_n_oe, .charge_status_n_oe, .aux_status_n_oe);
   chgtc_pins i_chgtc_pins (.input_good_n_oe, .charge_status_n_oe, .aux_status_n_oe,
      .input_good_n, .charge_status_n, .aux_status_n);
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
   endtask : tick
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
   endtask : rd
   task automatic done_test(input string s);
      $display("test %s finished", s);
   endtask : done_test
   task automatic end_of_test();
      $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : end_of_test
   always @(posedge clk) begin
      rd_q <= reg_rd;
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         end_of_test();
      end
      if (rd_q) begin
         rexp = exp_q.pop_front();
         `CHK("read data", rexp, reg_rdata)
      end
   end
   initial begin
      {reg_wr, reg_rd, detection_abort_flag, charger_detect_enable, bus_valid_debounced} = '0;
      {detect_done, detect_dedicated_port, charger_mode_boost, input_valid, buck_switching} = '0;
      {charging_active, charge_topoff_or_done, charge_fault, timer_fault} = '0;
      {thermal_shutdown, sys_lockout, ship_exit_input, reg_addr, reg_wdata} = '0;
      {port_connection_state, detect_line_drive_pos, detect_line_drive_neg} = 7'h0d;
      detect_ilim_code = 7'h20;
      rst = 1'b1;
      tick(20);
      rst <= 1'b0;
      rd(8'hd2, 8'h02);
      rd(8'hd4, 8'h1f);
      rd(8'hd6, 8'h0c);
      rd(8'hd7, 8'h18);
      rd(8'hd8, 8'h0a);
      rd(8'h10, 8'h00);
      wr(8'hd8, 8'h14);
      rd(8'hd8, 8'h0a);
      wr(8'hdb, 8'h0c);
      wr(8'hd8, 8'h14);
      n = $random(seed);
      wr(8'hd9, n[7:0] & 8'h7f);
      tick(1);
      `CHK("charge code", 6'h14, fast_charge_current_code)
      `CHK("topoff threshold", n[3:0], topoff_threshold_code)
      `CHK("topoff time", n[6:4], topoff_time_code)
      done_test("registers");
      for (int r = 1; r < 4; r++) begin
         n = ($random(seed) & 32'h13) | (r << 2);
         wr(8'hd4, n[7:0]);
         rd(8'hd4, n[7:0]);
         `CHK("port role", 2'(r), typec_ctrl.port_role_select)
         `CHK("prefer sink", n[4], typec_ctrl.prefer_sink_enable)
         `CHK("low power detect", n[1], typec_ctrl.low_power_sink_detect)
      end
      wr(8'hd4, 8'h3e);
      charger_mode_boost <= 1'b1;
      tick(3);
      `CHK("force recovery", 1'b1, typec_ctrl.force_recovery)
      `CHK("boost by mode", 1'b1, reverse_boost_enable)
      `CHK("input good pin", 1'b0, input_good_n)
      wr(8'hd4, 8'h1f);
      charger_mode_boost <= 1'b0;
      port_connection_state <= 3'h2;
      tick(3);
      `CHK("force cleared", 1'b0, typec_ctrl.force_recovery)
      `CHK("boost by state", 1'b1, reverse_boost_enable)
      done_test("port control");
      for (int c = 0; c < 4; c++) begin
         wr(8'hd2, 8'(8'h40 | (c << 4) | ((3 - c) << 2)));
         tick(1);
         `CHK("manual drive", {2'(c), 2'(3 - c)}, line_drive)
      end
      wr(8'hd2, 8'h02);
      tick(2);
      `CHK("auto drive", 4'ha, line_drive)
      port_connection_state <= 3'h0;
      wr(8'hd2, 8'h00);
      tick(2);
      `CHK("detect drive", 4'hd, line_drive)
      done_test("data lines");
      charger_detect_enable <= 1'b1;
      bus_valid_debounced <= 1'b1;
      n = 0;
      while (detect_run !== 1'b1 && n < 8) begin
         tick(1);
         n++;
      end
      `CHK("detect run", 1'b1, detect_run)
      detection_abort_flag <= 1'b1;
      tick(2);
      `CHK("detect aborted", 1'b0, detect_run)
      detection_abort_flag <= 1'b0;
      detect_done <= 1'b1;
      tick(3);
      `CHK("input limit", 7'h20, input_current_limit_code)
      done_test("detection");
      {input_valid, buck_switching, charging_active} <= 3'b111;
      tick(4);
      `CHK("input good pin", 1'b0, input_good_n)
      n = 0;
      repeat (4 * HALF) begin
         tick(1);
         n += (charge_status_n === 1'b1);
      end
      `CHK("blink high cycles", 2 * HALF, n)
      {charging_active, charge_topoff_or_done} <= 2'b01;
      tick(4);
      `CHK("top-off pin", 1'b0, charge_status_n)
      charge_fault <= 1'b1;
      tick(4);
      `CHK("fault pin", 1'b1, charge_status_n)
      {charge_fault, charge_topoff_or_done} <= 2'b00;
      `CHK("aux idle", 1'b1, aux_status_n)
      for (int k = 0; k < 3; k++) begin
         {sys_lockout, thermal_shutdown, timer_fault} <= 3'(1 << k);
         tick(3);
         `CHK("aux fault", 1'b0, aux_status_n)
      end
      {sys_lockout, thermal_shutdown, timer_fault, detect_done} <= 4'h0;
      wr(8'he5, 8'h06);
      tick(1);
      `CHK("aux manual high", 1'b1, aux_status_n)
      wr(8'he5, 8'h02);
      tick(1);
      `CHK("aux manual low", 1'b0, aux_status_n)
      wr(8'he5, 8'h01);
      {charger_detect_enable, detect_done, detect_dedicated_port} <= 3'b001;
      tick(2);
      `CHK("aux detect start", 1'b0, aux_status_n)
      {charger_detect_enable, detect_done} <= 2'b11;
      tick(5);
      `CHK("aux dedicated", 1'b0, aux_status_n)
      {charger_detect_enable, detect_done, detect_dedicated_port} <= 3'b000;
      tick(2);
      {charger_detect_enable, detect_done} <= 2'b11;
      tick(5);
      `CHK("aux standard", 1'b1, aux_status_n)
      charger_detect_enable <= 1'b0;
      tick(3);
      `CHK("aux restart low", 1'b0, aux_status_n)
      done_test("status pins");
      wr(8'he5, 8'h08);
      ship_exit_input <= 1'b1;
      tick(EXIT_MS * TICK / 2);
      `CHK("ship held", 1'b0, battery_switch_on)
      tick(EXIT_MS * TICK);
      `CHK("ship exit", 1'b1, battery_switch_on)
      ship_exit_input <= 1'b0;
      rd(8'he5, 8'h00);
      {input_valid, buck_switching, ship_exit_input} <= 3'b001;
      tick(RST_MS * TICK + 8);
      `CHK("system reset", 1'b0, battery_switch_on)
      ship_exit_input <= 1'b0;
      tick(6);
      `CHK("reset release", 1'b1, battery_switch_on)
      done_test("ship mode");
      tick(3);
      end_of_test();
   end
endmodule : chgtc_core_bench
bind chgtc_core chgtc_core_chk i_chgtc_core_chk (.clk, .rst, .reg_wr, .reg_rd, .reg_addr,
   .reg_wdata, .reg_rdata, .detection_abort_flag, .detect_run, .port_connection_state,
   .charger_mode_boost, .reverse_boost_enable, .typec_ctrl, .input_valid, .buck_switching,
   .charge_topoff_or_done, .charge_fault, .battery_regulation_voltage_code,
   .fast_charge_current_code, .input_good_n_oe, .charge_status_n_oe);
`default_nettype wire
